/* dppfc_defs.vh */
// register offsets, field positions and reset values for the dual port pin block
`ifndef DPPFC_DEFS_VH
`define DPPFC_DEFS_VH
`define DPPFC_ADDR_W 12
`define DPPFC_OFF_NARROW_LATCH 12'h000
`define DPPFC_OFF_NARROW_DIR 12'h004
`define DPPFC_OFF_NARROW_ROUTE 12'h00C
`define DPPFC_OFF_WIDE_LATCH 12'h010
`define DPPFC_OFF_WIDE_DIR 12'h014
`define DPPFC_OFF_WIDE_SEG 12'h018
`define DPPFC_NARROW_LSB 1
`define DPPFC_NARROW_MSB 4
`define DPPFC_NARROW_W 4
`define DPPFC_WIDE_W 7
`define DPPFC_NARROW_LATCH_RST 4'h0
`define DPPFC_NARROW_DIR_RST 4'h0
`define DPPFC_NARROW_ROUTE_RST 4'hF
`define DPPFC_WIDE_LATCH_RST 7'h00
`define DPPFC_WIDE_DIR_RST 7'h00
`define DPPFC_WIDE_SEG_RST 7'h00
`endif

/* dppfc_sync.v */
// two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dppfc_sync #(
    parameter W = 4
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta;
    // first stage is read by the second stage only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // dppfc_sync
`default_nettype wire

/* dppfc_top.v */
// dual general-purpose pin ports with per-bit role selection, apb register access
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dppfc_defs.vh"
// Notes on behaviour
// - four-pin port, per-bit direction and input-routing bits select each pin mode
// - reset clears four-pin latch and direction, sets routing bits to one
// - direction 0, routing 1: digital input feeding interrupt and timer inputs
// - direction 0, routing 0: analog and wake-up path, digital input buffer off
// - direction 1: pin driven from latch regardless of routing bit
// - four-pin data read: 0, pin level, or latch depending on mode
// - routing register holds bits 4 to 1, each reset to one
// - seven-pin port, direction bit 0 input, 1 output
// - reset clears seven-pin latch, direction and segment-select
// - segment-select 1 outputs lcd segment; else direction 1 drives latch, uart
// - seven-pin data read: pin level, 0, or latch depending on mode
module dppfc_top (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] narrow_port_in,
    output reg [3:0] narrow_port_out,
    output reg [3:0] narrow_port_oe,
    output reg [3:0] narrow_port_digital_in,
    output reg [3:0] narrow_port_analog_sel,
    input wire [6:0] wide_port_in,
    output reg [6:0] wide_port_out,
    output reg [6:0] wide_port_oe,
    input wire [6:0] lcd_segment,
    input wire uart_tx,
    input wire [6:0] uart_pin_sel
);
    reg [3:0] narrow_port_out_latch;
    reg [3:0] narrow_port_direction;
    reg [3:0] narrow_port_input_routing;
    reg [6:0] wide_port_out_latch;
    reg [6:0] wide_port_direction;
    reg [6:0] wide_port_segment_select;
    wire [3:0] narrow_sync;
    wire [6:0] wide_sync;
    wire [6:0] wide_sync_seg;
    reg [3:0] narrow_read;
    reg [6:0] wide_read;
    reg [31:0] next_prdata;
    reg hit;
    wire [11:0] addr;
    wire wr_en;
    wire rd_en;
    integer i;

    assign addr = paddr[11:0];
    assign wr_en = psel & penable & pwrite & ~pready;
    assign rd_en = psel & penable & ~pwrite & ~pready;

    dppfc_sync #(.W(4)) u_narrow_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(narrow_port_in),
        .sync_out(narrow_sync)
    );
    dppfc_sync #(.W(7)) u_wide_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(wide_port_in),
        .sync_out(wide_sync)
    );
    assign wide_sync_seg = lcd_segment;

    // register writes, low byte lane only carries data
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            narrow_port_out_latch <= `DPPFC_NARROW_LATCH_RST;
            narrow_port_direction <= `DPPFC_NARROW_DIR_RST;
            narrow_port_input_routing <= `DPPFC_NARROW_ROUTE_RST;
            wide_port_out_latch <= `DPPFC_WIDE_LATCH_RST;
            wide_port_direction <= `DPPFC_WIDE_DIR_RST;
            wide_port_segment_select <= `DPPFC_WIDE_SEG_RST;
        end else if (wr_en && pstrb[0]) begin
            case (addr)
                `DPPFC_OFF_NARROW_LATCH: begin
                    narrow_port_out_latch <= pwdata[`DPPFC_NARROW_MSB:`DPPFC_NARROW_LSB];
                end
                `DPPFC_OFF_NARROW_DIR: begin
                    narrow_port_direction <= pwdata[`DPPFC_NARROW_MSB:`DPPFC_NARROW_LSB];
                end
                `DPPFC_OFF_NARROW_ROUTE: begin
                    narrow_port_input_routing <= pwdata[`DPPFC_NARROW_MSB:`DPPFC_NARROW_LSB];
                end
                `DPPFC_OFF_WIDE_LATCH: begin
                    wide_port_out_latch <= pwdata[6:0];
                end
                `DPPFC_OFF_WIDE_DIR: begin
                    wide_port_direction <= pwdata[6:0];
                end
                `DPPFC_OFF_WIDE_SEG: begin
                    wide_port_segment_select <= pwdata[6:0];
                end
                default: begin
                end
            endcase
        end
    end

    // per-bit read-back selection
    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            if (narrow_port_direction[i]) begin
                narrow_read[i] = narrow_port_out_latch[i];
            end else if (narrow_port_input_routing[i]) begin
                narrow_read[i] = narrow_sync[i];
            end else begin
                narrow_read[i] = 1'b0;
            end
        end
        for (i = 0; i < 7; i = i + 1) begin
            // wide read mux; dir 1 with seg 0 also returns the latch
            if (wide_port_direction[i]) begin
                wide_read[i] = wide_port_out_latch[i];
            end else if (wide_port_segment_select[i]) begin
                wide_read[i] = 1'b0;
            end else begin
                wide_read[i] = wide_sync[i];
            end
        end
    end

    always @* begin
        next_prdata = 32'h00000000;
        hit = 1'b1;
        case (addr)
            `DPPFC_OFF_NARROW_LATCH: next_prdata = {27'h0000000, narrow_read, 1'b0};
            `DPPFC_OFF_NARROW_DIR: next_prdata = {27'h0000000, narrow_port_direction, 1'b0};
            `DPPFC_OFF_NARROW_ROUTE: next_prdata = {27'h0000000, narrow_port_input_routing, 1'b0};
            `DPPFC_OFF_WIDE_LATCH: next_prdata = {25'h0000000, wide_read};
            `DPPFC_OFF_WIDE_DIR: next_prdata = {25'h0000000, wide_port_direction};
            `DPPFC_OFF_WIDE_SEG: next_prdata = {25'h0000000, wide_port_segment_select};
            default: hit = 1'b0;
        endcase
    end

    // apb answer: one wait state, error on unmapped address
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (rd_en) begin
                prdata <= next_prdata;
            end
        end
    end

    // pin drive and function routing, registered outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            narrow_port_out <= 4'h0;
            narrow_port_oe <= 4'h0;
            narrow_port_digital_in <= 4'h0;
            narrow_port_analog_sel <= 4'h0;
            wide_port_out <= 7'h00;
            wide_port_oe <= 7'h00;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                narrow_port_oe[i] <= narrow_port_direction[i];
                narrow_port_out[i] <= narrow_port_out_latch[i];
                // digital input feeds interrupt and timer
                narrow_port_digital_in[i] <= ~narrow_port_direction[i]
                    & narrow_port_input_routing[i] & narrow_sync[i];
                // analog path, digital buffer gated off
                narrow_port_analog_sel[i] <= ~narrow_port_direction[i]
                    & ~narrow_port_input_routing[i];
            end
            for (i = 0; i < 7; i = i + 1) begin
                // segment wins, else latch, latch 1 lets uart through
                if (wide_port_segment_select[i]) begin
                    wide_port_oe[i] <= 1'b1;
                    wide_port_out[i] <= wide_sync_seg[i];
                end else begin
                    wide_port_oe[i] <= wide_port_direction[i];
                    wide_port_out[i] <= wide_port_out_latch[i]
                        & (~uart_pin_sel[i] | uart_tx);
                end
            end
        end
    end
endmodule // dppfc_top
`default_nettype wire

/* dppfc_top_sva.sv */
// assertion checker for the dual port pin block
`timescale 1ns/1ps
`default_nettype none
module dppfc_top_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] narrow_port_oe,
    input wire logic [3:0] narrow_port_digital_in,
    input wire logic [3:0] narrow_port_analog_sel,
    input wire logic [6:0] wide_port_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
    property p_rdy_time; psel && !penable |-> ##2 pready; endproperty
    a_rdy_time: assert property (p_rdy_time) else $error("pready late");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
    property p_rd_hold; $changed(prdata) |-> pready; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
    property p_ana; (narrow_port_analog_sel & narrow_port_digital_in) == 4'h0; endproperty
    a_ana: assert property (p_ana) else $error("analog pin feeds digital");
    property p_out_ana; (narrow_port_oe & narrow_port_analog_sel) == 4'h0; endproperty
    a_out_ana: assert property (p_out_ana) else $error("output pin on analog");
    property p_out_dig; (narrow_port_oe & narrow_port_digital_in) == 4'h0; endproperty
    a_out_dig: assert property (p_out_dig) else $error("output pin feeds digital");
    property p_rst; $rose(rst_n) |-> narrow_port_oe == 4'h0 && wide_port_oe == 7'h00
        && narrow_port_analog_sel == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("pins not inputs after reset");
endmodule // dppfc_top_sva
`default_nettype wire

/* dppfc_pins.sv */
// pin model: driven pins follow the design, released pins the outside level
`timescale 1ns/1ps
`default_nettype none
module dppfc_pins (
    input wire logic [3:0] n_oe,
    input wire logic [3:0] n_out,
    input wire logic [3:0] n_ext,
    input wire logic [6:0] w_oe,
    input wire logic [6:0] w_out,
    input wire logic [6:0] w_ext,
    output logic [3:0] n_pin,
    output logic [6:0] w_pin
);
    assign n_pin = (n_oe & n_out) | (~n_oe & n_ext);
    assign w_pin = (w_oe & w_out) | (~w_oe & w_ext);
endmodule // dppfc_pins
`default_nettype wire

/* dppfc_top_test.sv */
// self-checking bench for the dual port pin block
`timescale 1ns/1ps
`default_nettype none
module dppfc_top_test;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ut = 0, pready, pslverr, er;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 4'hF, n_in, n_out, n_oe, n_dig, n_ana, n_ext = 0;
    logic [6:0] w_in, w_out, w_oe, w_ext = 0, lcd = 0, usel = 0;
    logic [11:0] ra[3] = '{12'h004, 12'h014, 12'h018};
    int num_errors = 0, checks_done = 0, cyc = 0;
    always #20 clk = ~clk;
    dppfc_top i_dppfc_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .narrow_port_in(n_in), .narrow_port_out(n_out),
        .narrow_port_oe(n_oe), .narrow_port_digital_in(n_dig), .narrow_port_analog_sel(n_ana),
        .wide_port_in(w_in), .wide_port_out(w_out), .wide_port_oe(w_oe), .lcd_segment(lcd),
        .uart_tx(ut), .uart_pin_sel(usel));
    dppfc_pins i_dppfc_pins (.n_oe(n_oe), .n_out(n_out), .n_ext(n_ext), .w_oe(w_oe),
        .w_out(w_out), .w_ext(w_ext), .n_pin(n_in), .w_pin(w_in));
    task print_verdict;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // apb access; waits for pready, no fixed latency assumed
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        xfer(0, 12'h00C, 0); chk("route", 32'h1E, rd);
        for (int i = 0; i < 3; i++) begin
            xfer(0, ra[i], 0); chk("ctl", 32'h0, rd);
        end
        n_ext <= 4'b1100;
        xfer(1, 12'h000, 32'h0C);
        xfer(1, 12'h004, 32'h06);
        xfer(1, 12'h00C, 32'h0A);
        repeat (4) @(posedge clk);
        xfer(0, 12'h000, 0); chk("n_read", 32'h0C, rd);
        chk("n_oe", 4'b0011, n_oe);
        chk("n_out", 4'b0010, n_out & n_oe);
        chk("n_ana", 4'b1000, n_ana);
        chk("n_dig", 4'b0100, n_dig);
        n_ext <= 4'b0000;
        // pstrb low: write dropped without error
        pstrb <= 4'h0;
        xfer(1, 12'h000, 32'h1E);
        pstrb <= 4'hF;
        repeat (4) @(posedge clk);
        xfer(0, 12'h000, 0); chk("n_read2", 32'h04, rd);
        chk("n_dig2", 4'b0000, n_dig);
        w_ext <= 7'b1110000;
        lcd <= 7'b0101010;
        usel <= 7'b0000100;
        xfer(1, 12'h010, 32'h56);
        xfer(1, 12'h014, 32'h0D);
        xfer(1, 12'h018, 32'h03);
        repeat (4) @(posedge clk);
        xfer(0, 12'h010, 0); chk("w_read", 32'h74, rd);
        chk("w_oe", 7'h0F, w_oe);
        chk("w_out", 7'h02, w_out & w_oe);
        ut <= 1;
        repeat (3) @(posedge clk);
        chk("w_uart", 7'h06, w_out & w_oe);
        xfer(1, 12'h008, 32'hFF); chk("err_w", 1, er);
        xfer(0, 12'h008, 0); chk("err_r", 32'h0, rd);
        chk("err_r_flag", 1, er);
        print_verdict;
    end
endmodule // dppfc_top_test
bind dppfc_top dppfc_top_sva i_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .narrow_port_oe(narrow_port_oe), .narrow_port_digital_in(narrow_port_digital_in),
    .narrow_port_analog_sel(narrow_port_analog_sel), .wide_port_oe(wide_port_oe));
`default_nettype wire
